// file: src/dcmc_pkg.sv
// Constants, register map and carrier types of the dual clock mode controller
package dcmc_pkg;
  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OSC_MODE_ADDR = 8'hCA;
  localparam logic [7:0] PORT_WAKE_ADDR = 8'hC0;
  // Field positions of oscillator_mode_control
  localparam int HALT_BIT = 1;
  localparam int CLKSEL_BIT = 2;
  localparam int MODE_LSB = 3;
  localparam int MODE_MSB = 4;
  // Reset values
  localparam logic [7:0] OSC_MODE_RST = 8'h00;
  localparam logic [7:0] PORT_WAKE_RST = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // CPU mode field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_GREEN = 2'h2;
  // Instruction cycle divisors
  localparam int DIV_HIGH_FAST = 4;
  localparam int DIV_HIGH_SLOW = 8;
  localparam int DIV_LOW = 4;
  localparam int DIV_W = 3;
  // Oscillator warm-up after power-down, in high RC periods
  localparam int WARMUP_TICKS = 64;
  localparam int WARMUP_W = 7;
  // Slow to normal settle time software must respect, in ms
  localparam int SETTLE_MS = 20;
  // Port widths
  localparam int PORT_W = 8;
  // Sequencer states
  typedef enum logic [1:0] {st_run, st_green, st_sleep, st_warmup} dcmc_state_type;
  // Software control bits of oscillator_mode_control
  typedef struct packed {
    logic [1:0] cpu_mode_field;
    logic low_clock_select;
    logic high_osc_halt;
  } dcmc_ctrl_type;
  // Wakeup sources from neighbouring blocks
  typedef struct packed {
    logic timer0_ovf;
    logic timer0_run;
    logic adc_done;
    logic converter_on;
  } dcmc_wake_type;
endpackage

// file: src/dcmc_sync.sv
// Two-stage synchroniser with a rising-edge pulse taken after the second stage
`timescale 1ns/1ps
`default_nettype none
module dcmc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta;
  // Delayed copy for edge detection
  logic [WIDTH-1:0] last;

  // Shift chain, frozen while ce is low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      level_o <= '0;
      last <= '0;
    end else if (ce_i) begin
      meta <= async_i;
      level_o <= meta;
      last <= level_o;
    end
  end

  // Rising edge of the settled level
  assign rise_o = level_o & ~last & {WIDTH{ce_i}};
endmodule
`default_nettype wire

// file: src/dcmc_top.sv
// Clock selection, instruction rate and operating mode sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: High clock only from internal fast RC
// R2: Low clock RC or crystal, fixed option
// R3: Normal mode divides high clock by 4/8
// R4: Slow mode divides low clock by 4
// R5: Halt bit stops only fast RC
// R6: Clock-select bit picks high or low clock
// R7: Mode field: 00 normal, 01 sleep, 10 green
// R8: Sleep stops both oscillators and execution
// R9: Low oscillator stops only in sleep; the code also keeps it off through warm-up unless the watchdog strap is set
// R10: Watchdog always-on keeps low RC in sleep
// R11: Low RC also clocks the watchdog
// R12: Converter works only with fast RC running
// R13: Sleep exits only by wake pin or reset
// R14: Software waits 20ms before leaving slow
// R15: Green exits by port or running timer0
// R16: Green exits on conversion done if armed
// R17: Converter wake disarmed if off or halted
// R18: Sleep wake waits 64 fast RC periods
// R19: Green wake has no warm-up delay
// R20: Per-pin enable gates port wake
// R21: Any wake clears mode field to 00
// R22: Clock switch is glitch free
module dcmc_top
  import dcmc_pkg::*;
#(
  parameter int WARMUP = WARMUP_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic high_speed_rc_osc_i,
  input wire logic low_speed_rc_osc_i,
  input wire logic crystal_osc_i,
  input wire logic crystal_low_clock_option_i,
  input wire logic high_div8_option_i,
  input wire logic wdt_always_on_i,
  input wire logic [PORT_W-1:0] wake_port_i,
  input wire dcmc_wake_type wake_src_i,
  output logic high_speed_rc_osc_en_o,
  output logic low_speed_rc_osc_en_o,
  output logic sys_tick_o,
  output logic cpu_tick_o,
  output logic cpu_run_o,
  output logic wdt_tick_o,
  output logic converter_allow_o,
  output logic sys_low_o,
  output dcmc_state_type state_o
);
  // Software control bits
  dcmc_ctrl_type ctrl;
  // Per-pin port wake enables
  logic [PORT_W-1:0] port_wake_enable;
  // Sequencer state
  dcmc_state_type state;
  // Straps caught after reset release
  logic xtal_opt;
  logic div8_opt;
  logic wdt_on_opt;
  logic strap_done;
  // Converter wake armed at green entry
  logic adc_armed;
  // Warm-up counter in fast RC periods
  logic [WARMUP_W-1:0] warm_cnt;
  // Instruction divider
  logic [DIV_W-1:0] div_cnt;
  // Synchronised oscillators and port
  logic hosc_tick;
  logic rc_low_tick;
  logic xtal_tick;
  logic low_tick;
  logic [PORT_W-1:0] port_level;
  logic [PORT_W-1:0] port_last;
  // Wake conditions and mode requests
  logic port_wake;
  logic green_wake;
  logic enter_sleep;
  logic enter_green;

  // Mode field decode used in several places
  function automatic logic mode_is(input logic [1:0] field, input logic [1:0] code);
    mode_is = (field == code);
  endfunction

  // Oscillator waveforms arrive asynchronously
  dcmc_sync #(.WIDTH(1)) u_hosc_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(high_speed_rc_osc_i),
    .level_o(),
    .rise_o(hosc_tick)
  );

  dcmc_sync #(.WIDTH(1)) u_lrc_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(low_speed_rc_osc_i),
    .level_o(),
    .rise_o(rc_low_tick)
  );

  dcmc_sync #(.WIDTH(1)) u_xtal_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(crystal_osc_i),
    .level_o(),
    .rise_o(xtal_tick)
  );

  // Port pins for level-change wake
  dcmc_sync #(.WIDTH(PORT_W)) u_port_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(wake_port_i),
    .level_o(port_level),
    .rise_o()
  );

  // Straps sampled once after reset release
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      strap_done <= 1'b0;
      xtal_opt <= 1'b0;
      div8_opt <= 1'b0;
      wdt_on_opt <= 1'b0;
    end else if (ce_i && !strap_done) begin
      strap_done <= 1'b1;
      xtal_opt <= crystal_low_clock_option_i; // R2
      div8_opt <= high_div8_option_i; // R3
      wdt_on_opt <= wdt_always_on_i; // R10
    end
  end

  // Low clock source fixed by option, never by a register
  assign low_tick = xtal_opt ? xtal_tick : rc_low_tick; // R2

  // Port change detect, each pin gated by its enable
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      port_last <= '0;
    end else if (ce_i) begin
      port_last <= port_level;
    end
  end
  assign port_wake = |((port_level ^ port_last) & port_wake_enable); // R20

  // Green wake sources; timer only while running, converter only if armed
  assign green_wake = port_wake
                    || (wake_src_i.timer0_ovf && wake_src_i.timer0_run) // R15
                    || (wake_src_i.adc_done && adc_armed); // R16

  // Mode requests seen by the sequencer while running
  assign enter_sleep = mode_is(ctrl.cpu_mode_field, MODE_SLEEP); // R7
  assign enter_green = mode_is(ctrl.cpu_mode_field, MODE_GREEN); // R7

  // Operating mode sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= st_run;
      warm_cnt <= '0;
      adc_armed <= 1'b0;
    end else if (ce_i) begin
      case (state)
        st_run: begin
          // Reserved code 11 leaves the mode unchanged
          if (enter_sleep) begin
            state <= st_sleep; // R8
          end else if (enter_green) begin
            state <= st_green;
            adc_armed <= wake_src_i.converter_on && !ctrl.high_osc_halt; // R17
          end
        end
        st_green: begin
          // Clocks keep running, so return at once
          if (green_wake) begin
            state <= st_run; // R19
            adc_armed <= 1'b0;
          end
        end
        st_sleep: begin
          // Only the wake pins leave sleep
          if (port_wake) begin
            state <= st_warmup; // R13
            warm_cnt <= '0;
          end
        end
        default: begin
          // Count fast RC periods while it restarts
          if (hosc_tick) begin
            if (warm_cnt == WARMUP_W'(WARMUP - 1)) begin
              state <= st_run; // R18
            end else begin
              warm_cnt <= warm_cnt + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Control register, port wake register and mode clearing on wake
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= dcmc_ctrl_type'(OSC_MODE_RST[MODE_MSB:HALT_BIT]);
      port_wake_enable <= PORT_WAKE_RST;
    end else if (ce_i) begin
      if (state == st_warmup && hosc_tick && warm_cnt == WARMUP_W'(WARMUP - 1)) begin
        // Power-down returns to normal mode on the high clock
        ctrl <= '0; // R21
      end else if (state == st_green && green_wake) begin
        // Green returns to the previous clock mode
        ctrl.cpu_mode_field <= MODE_NORMAL; // R21
      end else if (wr_i && addr_i == OSC_MODE_ADDR) begin
        ctrl.cpu_mode_field <= wdata_i[MODE_MSB:MODE_LSB]; // R7
        ctrl.low_clock_select <= wdata_i[CLKSEL_BIT]; // R6
        ctrl.high_osc_halt <= wdata_i[HALT_BIT]; // R5
      end
      if (wr_i && addr_i == PORT_WAKE_ADDR) begin
        port_wake_enable <= wdata_i; // R20
      end
    end
  end

  // Read data one cycle after the strobe; port wake reads as zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= READ_ZERO;
    end else if (ce_i) begin
      if (rd_i && addr_i == OSC_MODE_ADDR) begin
        rdata_o <= READ_ZERO;
        rdata_o[MODE_MSB:HALT_BIT] <= ctrl;
      end else begin
        rdata_o <= READ_ZERO;
      end
    end
  end

  // Oscillator enables; fast RC is the only high source
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      high_speed_rc_osc_en_o <= 1'b1;
      low_speed_rc_osc_en_o <= 1'b1;
    end else if (ce_i) begin
      high_speed_rc_osc_en_o <= (state == st_warmup)
                              || (!ctrl.high_osc_halt && state != st_sleep && !enter_sleep); // R1 R5 R8
      low_speed_rc_osc_en_o <= !(state == st_sleep || enter_sleep) || wdt_on_opt; // R9 R10
    end
  end

  // Source switch takes effect only on an edge of the new source
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sys_low_o <= 1'b0;
    end else if (ce_i) begin
      if (ctrl.low_clock_select && !sys_low_o && low_tick) begin
        sys_low_o <= 1'b1; // R22 R6
      end else if (!ctrl.low_clock_select && sys_low_o && hosc_tick) begin
        sys_low_o <= 1'b0; // R22 R14
      end
    end
  end

  // Selected system clock tick; nothing runs in sleep or warm-up
  assign sys_tick_o = (state == st_run || state == st_green)
                    && (sys_low_o ? low_tick : hosc_tick);
  assign cpu_run_o = (state == st_run) && !enter_sleep && !enter_green; // R8

  // Instruction cycle divider, restarted on every source change
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      div_cnt <= '0;
      cpu_tick_o <= 1'b0;
    end else if (ce_i) begin
      cpu_tick_o <= 1'b0;
      if (sys_low_o != ctrl.low_clock_select && (sys_low_o ? hosc_tick : low_tick)) begin
        div_cnt <= '0; // R22
      end else if (sys_tick_o) begin
        if (sys_low_o ? (div_cnt == DIV_W'(DIV_LOW - 1)) // R4
                      : (div_cnt == (div8_opt ? DIV_W'(DIV_HIGH_SLOW - 1) : DIV_W'(DIV_HIGH_FAST - 1)))) begin // R3
          div_cnt <= '0;
          cpu_tick_o <= cpu_run_o;
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end
    end
  end

  // Watchdog clock from the low RC whenever it runs
  assign wdt_tick_o = rc_low_tick && low_speed_rc_osc_en_o; // R11
  // Converter allowed only while the fast RC runs
  assign converter_allow_o = !ctrl.high_osc_halt && state != st_sleep
                           && state != st_warmup; // R12
  assign state_o = state;
endmodule
`default_nettype wire

// file: test/dcmc_top_asserts.sv
// Port-level assertions of the dual clock mode controller
`timescale 1ns/1ps
`default_nettype none
module dcmc_top_chk
  import dcmc_pkg::*;
#(
  parameter int WARMUP = WARMUP_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wdt_always_on_i,
  input wire logic high_speed_rc_osc_en_o,
  input wire logic low_speed_rc_osc_en_o,
  input wire logic cpu_run_o,
  input wire logic converter_allow_o,
  input wire dcmc_state_type state_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // First cycle after sleep
  sequence s_leave_sleep;
    state_o == st_sleep ##1 state_o != st_sleep;
  endsequence
  // First cycle of warm-up
  sequence s_enter_warm;
    state_o != st_warmup ##1 state_o == st_warmup;
  endsequence
  chk_sleep_warmup: assert property (s_leave_sleep |-> state_o == st_warmup)
    else $error("sleep left without warm-up");
  chk_warm_hold: assert property (s_enter_warm |-> (state_o == st_warmup) [*4])
    else $error("warm-up ended too early");
  chk_warm_end: assert property (s_enter_warm |-> ##[4:200] state_o == st_run)
    else $error("warm-up never reached run");
  chk_green_exit: assert property (state_o == st_green |=> state_o inside {st_green, st_run})
    else $error("green left through another state");
  chk_sleep_osc: assert property ((state_o == st_sleep) [*2] |-> !high_speed_rc_osc_en_o)
    else $error("fast oscillator running in sleep");
  chk_low_sleep: assert property ((state_o == st_sleep) [*2] |-> low_speed_rc_osc_en_o == wdt_always_on_i)
    else $error("low oscillator enable wrong in sleep");
  chk_low_awake: assert property (state_o inside {st_run, st_green} && $past(state_o) inside {st_run, st_green}
    |-> low_speed_rc_osc_en_o)
    else $error("low oscillator stopped while awake");
  chk_idle_cpu: assert property (state_o != st_run |-> !cpu_run_o)
    else $error("cpu running outside run state");
  chk_conv_sleep: assert property (state_o inside {st_sleep, st_warmup} |-> !converter_allow_o)
    else $error("converter allowed in sleep");
endmodule
bind dcmc_top dcmc_top_chk #(.WARMUP(WARMUP)) u_chk (.ref_clk_i, .rst_n_i, .wdt_always_on_i,
  .high_speed_rc_osc_en_o, .low_speed_rc_osc_en_o, .cpu_run_o, .converter_allow_o, .state_o);
`default_nettype wire

// file: test/test_dcmc_top.sv
// Self-checking bench of the dual clock mode controller
`timescale 1ns/1ps
`default_nettype none
module test_dcmc_top
  import dcmc_pkg::*;
();
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, div8 = 1'b0;
  logic hrc = 1'b0, lrc = 1'b0, xtal = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, wport = 8'h00, rdata;
  dcmc_wake_type wsrc = '0;
  logic hen, len, stick, ctick, crun, conv, slow;
  // Straps for the crystal option and the always-on watchdog, and the watchdog tick seen
  logic xopt = 1'b0, wdt_on = 1'b0, wtick;
  dcmc_state_type st;
  logic [31:0] seed = 32'h00015AD1, r;
  int bad_count = 0, comparisons = 0, k;
  dcmc_top #(.WARMUP(4)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .high_speed_rc_osc_i(hrc),
    .low_speed_rc_osc_i(lrc), .crystal_osc_i(xtal), .crystal_low_clock_option_i(xopt),
    .high_div8_option_i(div8), .wdt_always_on_i(wdt_on), .wake_port_i(wport), .wake_src_i(wsrc),
    .high_speed_rc_osc_en_o(hen), .low_speed_rc_osc_en_o(len), .sys_tick_o(stick),
    .cpu_tick_o(ctick), .cpu_run_o(crun), .wdt_tick_o(wtick), .converter_allow_o(conv),
    .sys_low_o(slow), .state_o(st));
  // Oscillators stand still while their enable is low
  always #2 clk = ~clk;
  always #12.3 hrc = (hen === 1'b1) ? ~hrc : 1'b0;
  always #40.7 lrc = (len === 1'b1) ? ~lrc : 1'b0;
  // Crystal half period in ns; every fourth crystal edge meets a reference rising edge
  localparam int XTAL_HALF = 61;
  always #(XTAL_HALF) xtal = ~xtal;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected read of a written value
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] w);
    return (a == OSC_MODE_ADDR) ? (w & 8'h1E) : READ_ZERO;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Gap cycle so a following write never drives the strobe twice in one step
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk("rdata", e, rdata);
  endtask
  task automatic wait_st(input dcmc_state_type s);
    int n;
    n = 0;
    while (st !== s && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("state", 8'(s), 8'(st));
  endtask
  // Counts system ticks within one instruction cycle
  task automatic meas(input logic [7:0] d);
    int n, m;
    n = 0;
    m = 0;
    while (ctick !== 1'b1 && m < 400) begin
      @(posedge clk);
      m++;
    end
    do begin
      @(posedge clk);
      n += stick;
      m++;
    end while (ctick !== 1'b1 && m < 800);
    chk("divisor", d, 8'(n));
  endtask
  // Reference cycles between two instruction ticks
  task automatic span(input logic [7:0] d);
    int m;
    m = 0;
    while (ctick !== 1'b1 && m < 400) begin
      @(posedge clk);
      m++;
    end
    m = 0;
    do begin
      @(posedge clk);
      m++;
    end while (ctick !== 1'b1 && m < 400);
    chk("span", d, 8'(m));
  endtask
  // Whether any watchdog tick shows within a window
  task automatic wdt_seen(input logic [7:0] e);
    int n;
    n = 0;
    repeat (120) begin
      @(posedge clk);
      n += (wtick === 1'b1);
    end
    chk("wdt_tick", e, 8'(n != 0));
  endtask
  // Wake stimulus: 0 enabled pin, 1 timer overflow, else timer overflow, converter done, disabled pins
  task automatic kick(input int n);
    r = rnd();
    if (n == 0) wport <= wport ^ 8'h01;
    if (n == 1) wsrc.timer0_ovf <= 1'b1;
    if (n >= 2) begin
      wsrc.timer0_ovf <= 1'b1;
      wsrc.adc_done <= 1'b1;
      wport <= wport ^ {r[7:1], 1'b0};
    end
    @(posedge clk);
    wsrc.timer0_ovf <= 1'b0;
    wsrc.adc_done <= 1'b0;
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("state", 8'(st_run), 8'(st));
    rdc(OSC_MODE_ADDR, OSC_MODE_RST);
    rdc(PORT_WAKE_ADDR, READ_ZERO);
    meas(8'h04);
    wdt_seen(8'h01);
    for (k = 0; k < 6; k++) begin
      r = rnd();
      r[4:3] = {2{r[3]}};
      wr8(OSC_MODE_ADDR, r[7:0]);
      wr8(r[15:8] | 8'h01, 8'hFF);
      repeat (2) @(posedge clk);
      chk("state", 8'(st_run), 8'(st));
      chk("high_en", 8'(!r[1]), 8'(hen));
      chk("low_en", 8'h01, 8'(len));
      chk("conv", 8'(!r[1]), 8'(conv));
      rdc(OSC_MODE_ADDR, exp_rd(OSC_MODE_ADDR, r[7:0]));
    end
    wr8(OSC_MODE_ADDR, 8'h04);
    repeat (80) @(posedge clk);
    chk("sys_low", 8'h01, 8'(slow));
    meas(8'h04);
    wr8(OSC_MODE_ADDR, 8'h06);
    meas(8'h04);
    wr8(OSC_MODE_ADDR, 8'h04);
    repeat (40) @(posedge clk);
    wr8(OSC_MODE_ADDR, 8'h00);
    repeat (80) @(posedge clk);
    chk("sys_low", 8'h00, 8'(slow));
    wr8(PORT_WAKE_ADDR, 8'h01);
    wsrc.converter_on <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wsrc.timer0_run <= (k == 1);
      wr8(OSC_MODE_ADDR, (k == 3) ? 8'h12 : 8'h10);
      repeat (3) @(posedge clk);
      chk("cpu_run", 8'h00, 8'(crun));
      chk("state", 8'(st_green), 8'(st));
      kick(k);
      repeat (8) @(posedge clk);
      if (k == 3) begin
        chk("state", 8'(st_green), 8'(st));
        kick(0);
        repeat (8) @(posedge clk);
      end
      chk("state", 8'(st_run), 8'(st));
      rdc(OSC_MODE_ADDR, (k == 3) ? 8'h02 : 8'h00);
    end
    wr8(OSC_MODE_ADDR, 8'h08);
    repeat (4) @(posedge clk);
    chk("state", 8'(st_sleep), 8'(st));
    chk("high_en", 8'h00, 8'(hen));
    chk("low_en", 8'h00, 8'(len));
    wdt_seen(8'h00);
    // Running timer and converter must still be ignored in sleep
    wsrc.timer0_run <= 1'b1;
    kick(3);
    repeat (8) @(posedge clk);
    chk("state", 8'(st_sleep), 8'(st));
    kick(0);
    wait_st(st_warmup);
    wait_st(st_run);
    rdc(OSC_MODE_ADDR, 8'h00);
    rst_n <= 1'b0;
    div8 <= 1'b1;
    xopt <= 1'b1;
    wdt_on <= 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    meas(8'h08);
    // Crystal as low source: four crystal periods per instruction
    wr8(OSC_MODE_ADDR, 8'h04);
    repeat (80) @(posedge clk);
    chk("sys_low", 8'h01, 8'(slow));
    span(8'(DIV_LOW * 2 * XTAL_HALF / 4));
    // Green entered from slow returns to slow
    wr8(OSC_MODE_ADDR, 8'h14);
    repeat (3) @(posedge clk);
    chk("state", 8'(st_green), 8'(st));
    kick(0);
    repeat (8) @(posedge clk);
    chk("state", 8'(st_run), 8'(st));
    chk("sys_low", 8'h01, 8'(slow));
    rdc(OSC_MODE_ADDR, 8'h04);
    // Sleep with the watchdog always on keeps the low RC alive
    wr8(OSC_MODE_ADDR, 8'h0C);
    repeat (4) @(posedge clk);
    chk("state", 8'(st_sleep), 8'(st));
    chk("high_en", 8'h00, 8'(hen));
    chk("low_en", 8'h01, 8'(len));
    wdt_seen(8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
